/* File: hw/wide_write_defs.svh */
// Constants for the wide burst write target and its initiator
`ifndef WIDE_WRITE_DEFS_SVH
`define WIDE_WRITE_DEFS_SVH

// Bus widths
`define AD_WIDTH 64
`define ADDR_WIDTH 32
`define CBE_WIDTH 8
`define CMD_WIDTH 4

// Bus commands accepted as writes
`define CMD_MEM_WRITE 4'h7
`define CMD_MEM_WRITE_INV 4'hf

// Address windows: count, size in address bits, base of each window
`define NUM_WINDOWS 2
`define WIN_ADDR_BITS 12
`define WIN0_BASE 20'h00001
`define WIN1_BASE 20'h00002

// Byte enables driven by the initiator (active low, all lanes on)
`define BE_ALL_ON 8'h00

// Initiator gives up after this many data-phase cycles without a claim
`define ABORT_CYCLES 3'd5

// Back-end store depth in QWORDs and index width
`define STORE_DEPTH 8
`define STORE_IDX_BITS 3

// Reset value of the target's captured address
`define ADDR_RESET 32'h0000_0000

`endif

/* File: hw/wide_write_pkg.sv */
// Types shared by the wide burst write target and initiator
package wide_write_pkg;

    // Claim speed relative to the window match
    typedef enum logic {
        SPEED_FAST = 1'b0,
        SPEED_SLOW = 1'b1
    } select_speed_t;

    // Target sequence
    typedef enum logic [4:0] {
        T_IDLE = 5'b00001,
        T_DECODE = 5'b00010,
        T_MATCH = 5'b00100,
        T_CLAIM = 5'b01000,
        T_LAST = 5'b10000
    } tgt_state_t;

    // Initiator sequence
    typedef enum logic [3:0] {
        M_IDLE = 4'b0001,
        M_ADDR = 4'b0010,
        M_DATA = 4'b0100,
        M_TURN = 4'b1000
    } ini_state_t;

endpackage

/* File: hw/wide_pci_if.sv */
// Bus and back-end wiring between the wide write target and initiator
`timescale 1ns/1ps
`include "wide_write_defs.svh"

interface wide_pci_if;
    // Drives of the initiator side
    logic [`AD_WIDTH-1:0] ad_out;
    logic ad_oe;
    logic [`CBE_WIDTH-1:0] cben_out;
    logic cben_oe;
    logic framen_out;
    logic framen_oe;
    logic req64n_out;
    logic req64n_oe;
    logic irdyn_out;
    logic irdyn_oe;
    // Drives of the target side
    logic devseln_out;
    logic devseln_oe;
    logic ack64n_out;
    logic ack64n_oe;
    logic trdyn_out;
    logic trdyn_oe;
    // Resolved bus levels, undriven lines sit high as if pulled up
    logic [`AD_WIDTH-1:0] ad;
    logic [`CBE_WIDTH-1:0] cben;
    logic framen;
    logic req64n;
    logic irdyn;
    logic devseln;
    logic ack64n;
    logic trdyn;
    // Local back-end side
    logic [`ADDR_WIDTH-1:0] local_addr_to_backend;
    logic wide_xfer_flag;
    logic [`NUM_WINDOWS-1:0] window_hit;
    logic backend_ready_n;
    logic [`AD_WIDTH-1:0] write_data_to_backend;
    logic low_dword_strobe_n;
    logic high_dword_strobe_n;

    // Pull-up resolution of each shared line
    assign ad = ad_oe ? ad_out : {`AD_WIDTH{1'b1}};
    assign cben = cben_oe ? cben_out : {`CBE_WIDTH{1'b1}};
    assign framen = framen_oe ? framen_out : 1'b1;
    assign req64n = req64n_oe ? req64n_out : 1'b1;
    assign irdyn = irdyn_oe ? irdyn_out : 1'b1;
    assign devseln = devseln_oe ? devseln_out : 1'b1;
    assign ack64n = ack64n_oe ? ack64n_out : 1'b1;
    assign trdyn = trdyn_oe ? trdyn_out : 1'b1;

    modport target (
        input ad, cben, framen, req64n, irdyn, backend_ready_n,
        output devseln_out, devseln_oe, ack64n_out, ack64n_oe, trdyn_out, trdyn_oe,
        output local_addr_to_backend, wide_xfer_flag, window_hit,
        output write_data_to_backend, low_dword_strobe_n, high_dword_strobe_n
    );

    modport initiator (
        input devseln, ack64n, trdyn,
        input local_addr_to_backend, wide_xfer_flag, window_hit,
        input write_data_to_backend, low_dword_strobe_n, high_dword_strobe_n,
        output ad_out, ad_oe, cben_out, cben_oe, framen_out, framen_oe,
        output req64n_out, req64n_oe, irdyn_out, irdyn_oe, backend_ready_n
    );
endinterface

/* File: hw/window_decode.sv */
// Address window decoder for the wide write target
`timescale 1ns/1ps
`include "wide_write_defs.svh"

module window_decode (
    input wire logic [`ADDR_WIDTH-1:0] addr,
    input wire logic [`CMD_WIDTH-1:0] cmd,
    output logic [`NUM_WINDOWS-1:0] match
);
    localparam int TAG_BITS = `ADDR_WIDTH - `WIN_ADDR_BITS;
    localparam logic [`NUM_WINDOWS*TAG_BITS-1:0] BASES = {`WIN1_BASE, `WIN0_BASE};

    logic is_write;

    // Only memory writes are claimed; reads belong to another path
    assign is_write = (cmd == `CMD_MEM_WRITE) || (cmd == `CMD_MEM_WRITE_INV);

    // One comparator per window on the upper address bits
    genvar w;
    generate
        for (w = 0; w < `NUM_WINDOWS; w = w + 1) begin : g_win
            assign match[w] = is_write &&
                (addr[`ADDR_WIDTH-1:`WIN_ADDR_BITS] == BASES[w*TAG_BITS +: TAG_BITS]);
        end
    endgenerate
endmodule

/* File: hw/wide_write_target.sv */
// Target end of the 64-bit burst write, bus side to local back-end
// How it works
// - Initiator drives address, command, wide request with frame.
// - Initiator drives byte enables and first QWORD next.
// - Present captured address and wide flag next cycle.
// - Raise window match as back-end chip select.
// - Slow speed claims the clock after match.
// - Accept wide request with ack together with claim.
// - Back-end ready means data taken two cycles later.
// - Assert target ready the cycle after back-end ready.
// - Hold target ready; present last accepted QWORD.
// - Initiator advances only after both readies were low.
// - Strobe both dwords after initiator and back-end ready.
// - Back-end writes only while both strobes low.
// - Initiator ends burst raising frame and wide request.
// - No end-of-burst hint during final hand-over.
// - Initiator releases bus after final completed phase.
// - Deassert claim, ack and ready after final phase.
// - Idle cycle clears match, strobes and stops driving.
`timescale 1ns/1ps
`include "wide_write_defs.svh"

module wide_write_target
    import wide_write_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    wide_pci_if.target bus,
    input wire select_speed_t select_response_speed,
    output logic busy,
    output logic [15:0] qwords_taken
);
    tgt_state_t state_r;
    tgt_state_t state_nxt;
    logic framen_prev_r;
    logic [`ADDR_WIDTH-1:0] addr_r;
    logic [`CMD_WIDTH-1:0] cmd_r;
    logic req64_r;
    logic [`NUM_WINDOWS-1:0] match;
    logic [`NUM_WINDOWS-1:0] hit_r;
    logic devseln_r;
    logic ack64n_r;
    logic trdyn_r;
    logic drive_r;
    logic strobe_n_r;
    logic [`AD_WIDTH-1:0] wdata_r;
    logic frame_start;
    logic phase_done;
    logic last_done;

    // Decode runs on the address held since the address phase
    window_decode u_decode (
        .addr(addr_r),
        .cmd(cmd_r),
        .match(match)
    );

    // A new frame is only a high-to-low step seen while idle
    assign frame_start = (state_r == T_IDLE) && framen_prev_r && !bus.framen;
    // A data phase completes when both readies are low together
    assign phase_done = (state_r == T_CLAIM) && !bus.irdyn && !trdyn_r;
    // Frame already high marks the final phase
    assign last_done = phase_done && bus.framen;

    // Previous frame level for start detection
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            framen_prev_r <= 1'b1;
        end else begin
            framen_prev_r <= bus.framen;
        end
    end

    // Sequence of one transaction
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            T_IDLE: begin
                if (frame_start) begin
                    state_nxt = T_DECODE;
                end
            end
            T_DECODE: begin
                if (match == '0) begin
                    state_nxt = T_IDLE; // Not ours, let the cycle pass
                end else if (select_response_speed == SPEED_SLOW) begin
                    state_nxt = T_MATCH;
                end else begin
                    state_nxt = T_CLAIM;
                end
            end
            T_MATCH: begin
                state_nxt = T_CLAIM;
            end
            T_CLAIM: begin
                if (last_done) begin
                    state_nxt = T_LAST;
                end
            end
            T_LAST: begin
                state_nxt = T_IDLE;
            end
            default: begin
                state_nxt = T_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_r <= T_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Address phase capture; shown to the back-end the next cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            addr_r <= `ADDR_RESET;
            cmd_r <= '0;
            req64_r <= 1'b0;
        end else if (frame_start) begin
            addr_r <= bus.ad[`ADDR_WIDTH-1:0];
            cmd_r <= bus.cben[`CMD_WIDTH-1:0];
            req64_r <= !bus.req64n;
        end else if (state_r == T_LAST) begin
            req64_r <= 1'b0; // Flag falls with the transaction
        end
    end

    // Window match held for the whole transfer, dropped in the idle cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            hit_r <= '0;
        end else if (state_r == T_DECODE) begin
            hit_r <= match;
        end else if (state_r == T_LAST) begin
            hit_r <= '0;
        end
    end

    // Claim and wide acknowledge, asserted and released together
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            devseln_r <= 1'b1;
            ack64n_r <= 1'b1;
        end else if ((state_r == T_MATCH) ||
                     ((state_r == T_DECODE) && (match != '0) &&
                      (select_response_speed == SPEED_FAST))) begin
            devseln_r <= 1'b0;
            ack64n_r <= !req64_r;
        end else if (last_done) begin
            devseln_r <= 1'b1;
            ack64n_r <= 1'b1;
        end
    end

    // Target ready follows back-end ready by one cycle while claimed
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            trdyn_r <= 1'b1;
        end else if (last_done) begin
            trdyn_r <= 1'b1;
        end else if ((state_r == T_CLAIM) ||
                     ((state_r == T_MATCH) || (state_nxt == T_CLAIM))) begin
            trdyn_r <= bus.backend_ready_n;
        end else begin
            trdyn_r <= 1'b1;
        end
    end

    // Sustained lines stay driven high one cycle before release
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            drive_r <= 1'b0;
        end else if ((state_nxt == T_CLAIM) && (state_r != T_CLAIM)) begin
            drive_r <= 1'b1;
        end else if (state_r == T_LAST) begin
            drive_r <= 1'b0;
        end
    end

    // QWORD accepted on the bus is handed over one cycle later
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wdata_r <= '0;
        end else if (phase_done) begin
            wdata_r <= bus.ad;
        end
    end

    // Both dword strobes mark the presented QWORD valid.
    // The final QWORD gets the same strobe as any other: nothing here
    // tells the back-end the burst ended, the dropped match does that.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            strobe_n_r <= 1'b1;
        end else begin
            strobe_n_r <= !(phase_done && !bus.backend_ready_n);
        end
    end

    // Status toward the user side
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            busy <= 1'b0;
            qwords_taken <= '0;
        end else begin
            busy <= (state_nxt != T_IDLE);
            if (!strobe_n_r) begin
                qwords_taken <= qwords_taken + 16'h0001;
            end
        end
    end

    // Port drives, all from flip-flops
    assign bus.devseln_out = devseln_r;
    assign bus.ack64n_out = ack64n_r;
    assign bus.trdyn_out = trdyn_r;
    assign bus.devseln_oe = drive_r;
    assign bus.ack64n_oe = drive_r;
    assign bus.trdyn_oe = drive_r;
    assign bus.local_addr_to_backend = addr_r;
    assign bus.wide_xfer_flag = req64_r;
    assign bus.window_hit = hit_r;
    assign bus.write_data_to_backend = wdata_r;
    assign bus.low_dword_strobe_n = strobe_n_r;
    assign bus.high_dword_strobe_n = strobe_n_r;
endmodule

/* File: hw/wide_write_initiator.sv */
// Far end: bus initiator of the wide burst write plus local back-end store
`timescale 1ns/1ps
`include "wide_write_defs.svh"

module wide_write_initiator
    import wide_write_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    wide_pci_if.initiator bus,
    input wire logic start,
    input wire logic [`ADDR_WIDTH-1:0] start_addr,
    input wire logic [3:0] qword_total,
    input wire logic [`AD_WIDTH-1:0] first_data,
    output logic busy,
    output logic aborted,
    output logic burst_done,
    output logic [7:0] stored_count,
    output logic [`AD_WIDTH-1:0] last_stored
);
    ini_state_t state_r;
    logic [3:0] left_r;
    logic [2:0] wait_r;
    logic [`AD_WIDTH-1:0] ad_r;
    logic [`CBE_WIDTH-1:0] cben_r;
    logic frame_r;
    logic req_r;
    logic irdy_r;
    logic bus_oe_r;
    logic irdy_oe_r;
    logic ready_n_r;
    logic hit_prev_r;
    logic [`STORE_IDX_BITS-1:0] idx_r;
    logic [`AD_WIDTH-1:0] store_r [`STORE_DEPTH];
    logic done_phase;

    // A phase completes only with both readies low
    assign done_phase = (state_r == M_DATA) && !irdy_r && !bus.trdyn;

    // Initiator sequence
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_r <= M_IDLE;
            left_r <= '0;
            wait_r <= '0;
            ad_r <= '0;
            cben_r <= '1;
            frame_r <= 1'b1;
            req_r <= 1'b1;
            irdy_r <= 1'b1;
            bus_oe_r <= 1'b0;
            irdy_oe_r <= 1'b0;
            aborted <= 1'b0;
        end else begin
            aborted <= 1'b0;
            case (state_r)
                M_IDLE: begin
                    if (start) begin
                        ad_r <= {32'h0000_0000, start_addr};
                        cben_r <= {4'hf, `CMD_MEM_WRITE};
                        frame_r <= 1'b0;
                        req_r <= 1'b0;
                        bus_oe_r <= 1'b1;
                        left_r <= (qword_total == 4'h0) ? 4'h1 : qword_total;
                        state_r <= M_ADDR;
                    end
                end
                M_ADDR: begin
                    ad_r <= first_data;
                    cben_r <= `BE_ALL_ON;
                    irdy_r <= 1'b0;
                    irdy_oe_r <= 1'b1;
                    wait_r <= '0;
                    if (left_r == 4'h1) begin
                        frame_r <= 1'b1;
                        req_r <= 1'b1;
                    end
                    state_r <= M_DATA;
                end
                M_DATA: begin
                    if (done_phase && (left_r == 4'h1)) begin
                        irdy_r <= 1'b1;
                        bus_oe_r <= 1'b0;
                        state_r <= M_TURN;
                    end else if (done_phase) begin
                        ad_r <= ad_r + 64'h1;
                        left_r <= left_r - 4'h1;
                        if (left_r == 4'h2) begin
                            frame_r <= 1'b1;
                            req_r <= 1'b1;
                        end
                    end else if (bus.devseln && (wait_r == `ABORT_CYCLES)) begin
                        // No claim: give the bus up rather than hang on it
                        irdy_r <= 1'b1;
                        frame_r <= 1'b1;
                        bus_oe_r <= 1'b0;
                        aborted <= 1'b1;
                        state_r <= M_TURN;
                    end else if (bus.devseln) begin
                        wait_r <= wait_r + 3'd1;
                    end
                end
                M_TURN: begin
                    irdy_oe_r <= 1'b0;
                    frame_r <= 1'b1;
                    req_r <= 1'b1;
                    state_r <= M_IDLE;
                end
                default: begin
                    state_r <= M_IDLE;
                end
            endcase
        end
    end

    // Back-end ready follows the chip select, two cycles ahead of data
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ready_n_r <= 1'b1;
            hit_prev_r <= 1'b0;
        end else begin
            ready_n_r <= !(|bus.window_hit);
            hit_prev_r <= |bus.window_hit;
        end
    end

    // Store writes and address counter step only on both strobes
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            idx_r <= '0;
            stored_count <= '0;
            last_stored <= '0;
        end else if ((|bus.window_hit) && !hit_prev_r) begin
            idx_r <= bus.local_addr_to_backend[`STORE_IDX_BITS+2:3];
        end else if (!bus.low_dword_strobe_n && !bus.high_dword_strobe_n) begin
            store_r[idx_r] <= bus.write_data_to_backend;
            last_stored <= bus.write_data_to_backend;
            idx_r <= idx_r + 3'd1;
            stored_count <= stored_count + 8'h01;
        end
    end

    // Completion seen as the match falling; status flops
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            burst_done <= 1'b0;
            busy <= 1'b0;
        end else begin
            burst_done <= hit_prev_r && !(|bus.window_hit);
            busy <= (state_r != M_IDLE) || start;
        end
    end

    assign bus.ad_out = ad_r;
    assign bus.ad_oe = bus_oe_r;
    assign bus.cben_out = cben_r;
    assign bus.cben_oe = bus_oe_r;
    assign bus.framen_out = frame_r;
    assign bus.framen_oe = bus_oe_r;
    assign bus.req64n_out = req_r;
    assign bus.req64n_oe = bus_oe_r;
    assign bus.irdyn_out = irdy_r;
    assign bus.irdyn_oe = irdy_oe_r;
    assign bus.backend_ready_n = ready_n_r;
endmodule

/* File: sim/wide_write_monitor.sv */
// Concurrent checks on the wide burst write bus and back-end signals
`timescale 1ns/1ps
`include "wide_write_defs.svh"

module wide_write_monitor
    import wide_write_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire select_speed_t select_response_speed,
    input wire logic [`AD_WIDTH-1:0] ad,
    input wire logic [`CBE_WIDTH-1:0] cben,
    input wire logic framen,
    input wire logic req64n,
    input wire logic irdyn,
    input wire logic devseln,
    input wire logic devseln_oe,
    input wire logic ack64n,
    input wire logic ack64n_oe,
    input wire logic trdyn,
    input wire logic trdyn_oe,
    input wire logic [`ADDR_WIDTH-1:0] local_addr_to_backend,
    input wire logic wide_xfer_flag,
    input wire logic [`NUM_WINDOWS-1:0] window_hit,
    input wire logic backend_ready_n,
    input wire logic [`AD_WIDTH-1:0] write_data_to_backend,
    input wire logic low_dword_strobe_n,
    input wire logic high_dword_strobe_n
);
    // One clock domain, so one clocking and one reset guard for all
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_addr_capture;
        $fell(framen) |=> local_addr_to_backend == $past(ad[31:0])
            && wide_xfer_flag == !$past(req64n);
    endproperty
    a_addr_capture: assert property (p_addr_capture) else $error("address or wide flag");

    property p_window0_hit;
        $fell(framen) && (cben[3:0] == `CMD_MEM_WRITE || cben[3:0] == `CMD_MEM_WRITE_INV)
            && ad[31:12] == `WIN0_BASE |-> ##2 window_hit == 2'h1;
    endproperty
    a_window0_hit: assert property (p_window0_hit) else $error("window match missing");

    property p_slow_claim;
        $rose(|window_hit) && select_response_speed == SPEED_SLOW |-> devseln ##1 $fell(devseln);
    endproperty
    a_slow_claim: assert property (p_slow_claim) else $error("slow claim not late");

    property p_ack_with_claim;
        $fell(devseln) |-> ack64n == !wide_xfer_flag;
    endproperty
    a_ack_with_claim: assert property (p_ack_with_claim) else $error("ack not with claim");

    // Final completed phase is excluded, there the ready drops instead
    property p_ready_follows;
        !devseln && !backend_ready_n && !(framen && !irdyn && !trdyn) |=> !trdyn;
    endproperty
    a_ready_follows: assert property (p_ready_follows) else $error("target ready late");

    property p_data_present;
        !irdyn && !trdyn |=> write_data_to_backend == $past(ad);
    endproperty
    a_data_present: assert property (p_data_present) else $error("wrong data to back-end");

    property p_strobe;
        !irdyn && !trdyn && !backend_ready_n |=> !low_dword_strobe_n && !high_dword_strobe_n;
    endproperty
    a_strobe: assert property (p_strobe) else $error("dword strobes missing");

    property p_strobe_pair;
        low_dword_strobe_n == high_dword_strobe_n;
    endproperty
    a_strobe_pair: assert property (p_strobe_pair) else $error("dword strobes split");

    property p_no_early_end;
        !low_dword_strobe_n |-> window_hit != 2'h0;
    endproperty
    a_no_early_end: assert property (p_no_early_end) else $error("match cleared early");

    property p_release_claim;
        framen && !irdyn && !trdyn && !devseln |=> devseln && ack64n && trdyn;
    endproperty
    a_release_claim: assert property (p_release_claim) else $error("claim not dropped");

    property p_idle_cycle;
        $rose(devseln) |=> window_hit == 2'h0 && !wide_xfer_flag && low_dword_strobe_n
            && !devseln_oe && !ack64n_oe && !trdyn_oe;
    endproperty
    a_idle_cycle: assert property (p_idle_cycle) else $error("idle cycle not clean");
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench joining the wide write target and initiator
`timescale 1ns/1ps
`include "wide_write_defs.svh"
`define CHK(g, e) chk(64'(g), 64'(e))

module tb_top
    import wide_write_pkg::*;
;
    logic ref_clk;
    logic rstn;
    select_speed_t speed;
    logic start;
    logic [31:0] start_addr;
    logic [3:0] qword_total;
    logic [63:0] first_data;
    logic t_busy, i_busy, aborted, burst_done;
    logic [15:0] qwords_taken;
    logic [7:0] stored_count;
    logic [63:0] last_stored;
    int n_errors, compares, claim_cnt, strobe_cnt;
    logic framen_d;
    logic [31:0] addr_seen;
    logic [3:0] cmd_seen;
    logic [1:0] hit_seen;

    wide_pci_if bus_if();

    wide_write_target u_wide_write_target (.ref_clk(ref_clk), .rstn(rstn), .bus(bus_if),
        .select_response_speed(speed), .busy(t_busy), .qwords_taken(qwords_taken));

    wide_write_initiator u_wide_write_initiator (.ref_clk(ref_clk), .rstn(rstn), .bus(bus_if),
        .start(start), .start_addr(start_addr), .qword_total(qword_total),
        .first_data(first_data), .busy(i_busy), .aborted(aborted), .burst_done(burst_done),
        .stored_count(stored_count), .last_stored(last_stored));

    wide_write_monitor u_wide_write_monitor (.ref_clk(ref_clk), .rstn(rstn),
        .select_response_speed(speed), .ad(bus_if.ad), .cben(bus_if.cben),
        .framen(bus_if.framen), .req64n(bus_if.req64n), .irdyn(bus_if.irdyn),
        .devseln(bus_if.devseln), .devseln_oe(bus_if.devseln_oe), .ack64n(bus_if.ack64n),
        .ack64n_oe(bus_if.ack64n_oe), .trdyn(bus_if.trdyn), .trdyn_oe(bus_if.trdyn_oe),
        .local_addr_to_backend(bus_if.local_addr_to_backend),
        .wide_xfer_flag(bus_if.wide_xfer_flag), .window_hit(bus_if.window_hit),
        .backend_ready_n(bus_if.backend_ready_n),
        .write_data_to_backend(bus_if.write_data_to_backend),
        .low_dword_strobe_n(bus_if.low_dword_strobe_n),
        .high_dword_strobe_n(bus_if.high_dword_strobe_n));

    always #5 ref_clk = ~ref_clk;

    // Wire watcher: address phase, match, claim cycles and strobe count
    always @(posedge ref_clk) begin
        framen_d <= bus_if.framen;
        if (!bus_if.framen && framen_d) begin
            addr_seen <= bus_if.ad[31:0];
            cmd_seen <= bus_if.cben[3:0];
            hit_seen <= 2'h0;
        end else begin
            hit_seen <= hit_seen | bus_if.window_hit;
        end
        if (!bus_if.devseln) claim_cnt <= claim_cnt + 1;
        if (!bus_if.low_dword_strobe_n) strobe_cnt <= strobe_cnt + 1;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        if (n_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Bounded wait for the end of a burst; a hang ends the run
    task automatic wait_end(output logic ab);
        int i;
        i = 0;
        ab = 1'b0;
        do begin
            @(negedge ref_clk);
            i++;
            if (aborted === 1'b1) ab = 1'b1;
        end while (burst_done !== 1'b1 && aborted !== 1'b1 && i < 200);
        if (i >= 200) begin
            n_errors++;
            give_verdict();
        end
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic launch(input select_speed_t spd, input logic [31:0] addr,
                          input logic [3:0] tot, input logic [63:0] d0);
        speed = spd;
        start_addr = addr;
        qword_total = tot;
        first_data = d0;
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        `CHK(i_busy, 1'b1);
    endtask

    // Full burst; claim length shows the select speed on the wire
    task automatic run_burst(input select_speed_t spd, input logic [31:0] addr,
                             input logic [3:0] tot, input logic [63:0] d0,
                             input logic [1:0] hit);
        int n, cl0, sb0;
        logic [7:0] st0;
        logic [15:0] tk0;
        logic ab;
        n = (tot == 4'h0) ? 1 : int'(tot);
        st0 = stored_count;
        tk0 = qwords_taken;
        cl0 = claim_cnt;
        sb0 = strobe_cnt;
        launch(spd, addr, tot, d0);
        wait_end(ab);
        `CHK(ab, 1'b0);
        `CHK({t_busy, i_busy}, 2'h0);
        `CHK(addr_seen, addr);
        `CHK(cmd_seen == `CMD_MEM_WRITE || cmd_seen == `CMD_MEM_WRITE_INV, 1'b1);
        `CHK(hit_seen, hit);
        `CHK(claim_cnt - cl0, n + ((spd == SPEED_SLOW) ? 1 : 2));
        `CHK(strobe_cnt - sb0, n);
        `CHK(16'(qwords_taken - tk0), n);
        `CHK(8'(stored_count - st0), n);
        `CHK(last_stored, d0 + 64'(n - 1));
        `CHK({bus_if.ad_oe, bus_if.irdyn_oe, bus_if.devseln_oe, bus_if.trdyn_oe}, 4'h0);
        `CHK({bus_if.window_hit, bus_if.low_dword_strobe_n}, 3'h1);
    endtask

    // Address outside both windows: never claimed, initiator gives up
    task automatic run_unclaimed();
        int cl0;
        logic [15:0] tk0;
        logic ab;
        cl0 = claim_cnt;
        tk0 = qwords_taken;
        launch(SPEED_SLOW, 32'h0000_3000, 4'h2, 64'h0000_0000_0000_0055);
        wait_end(ab);
        `CHK(ab, 1'b1);
        `CHK(hit_seen, 2'h0);
        `CHK(claim_cnt - cl0, 0);
        `CHK(qwords_taken, tk0);
    endtask

    // Reset in mid-burst must drop the target drives, ad_oe, the match and both strobes at once
    task automatic run_mid_reset();
        launch(SPEED_SLOW, 32'h0000_1010, 4'h6, 64'h0000_00aa_0000_0000);
        repeat (5) @(negedge ref_clk);
        rstn = 1'b0;
        @(negedge ref_clk);
        `CHK({bus_if.devseln_oe, bus_if.ack64n_oe, bus_if.trdyn_oe, bus_if.ad_oe}, 4'h0);
        `CHK(bus_if.window_hit, 2'h0);
        `CHK({bus_if.low_dword_strobe_n, bus_if.high_dword_strobe_n}, 2'h3);
        rstn = 1'b1;
        @(negedge ref_clk);
    endtask

    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        speed = SPEED_SLOW;
        start = 1'b0;
        start_addr = 32'h0000_0000;
        qword_total = 4'h0;
        first_data = 64'h0000_0000_0000_0000;
        n_errors = 0;
        compares = 0;
        claim_cnt = 0;
        strobe_cnt = 0;
        framen_d = 1'b1;
        hit_seen = 2'h0;
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        run_burst(SPEED_SLOW, 32'h0000_1000, 4'h3, 64'h1111_0000_2222_0000, 2'h1);
        run_burst(SPEED_FAST, 32'h0000_2008, 4'hf, 64'hffff_ffff_ffff_fffa, 2'h2);
        run_burst(SPEED_SLOW, 32'h0000_1ff8, 4'h0, 64'h0123_4567_89ab_cdef, 2'h1);
        run_unclaimed();
        run_mid_reset();
        run_burst(SPEED_FAST, 32'h0000_1000, 4'h1, 64'h0000_0000_0000_0001, 2'h1);
        give_verdict();
    end
endmodule
